// ==== design/sgi_dist_pkg.sv ====
package sgi_dist_pkg;
   localparam int NUM_PE  = 8;
   localparam int NUM_SGI = 16;
   localparam int PE_W    = 3;
   localparam int ID_W    = 4;
   localparam int LANES   = 4;
   localparam int BYTE_W  = 8;
   localparam int ERR_W   = 4;

   localparam logic [11:0] OFF_TYPE   = 12'h004;
   localparam logic [11:0] OFF_STATUS = 12'h010;
   localparam logic [11:0] OFF_SEND   = 12'hf00;
   localparam logic [11:0] OFF_PEND   = 12'hf20;
   localparam logic [11:0] PEND_MASK  = 12'hff0;
   localparam logic [3:0]  BE_ALL     = 4'hf;

   localparam int FILT_LO = 24;
   localparam int FILT_HI = 25;
   localparam int LIST_LO = 16;
   localparam int LIST_HI = 23;
   localparam int GRP_BIT = 15;
   localparam int ID_LO   = 0;
   localparam int ID_HI   = 3;
   localparam logic [31:0] SEND_WMASK = 32'h03ff800f;
   localparam logic [31:0] SEND_RST   = 32'h007f0000;

   typedef enum logic [1:0] {
      FILT_LIST   = 2'b00,
      FILT_OTHERS = 2'b01,
      FILT_SELF   = 2'b10,
      FILT_RSVD   = 2'b11
   } filter_e;

   localparam int ERR_RSV_RD = 0;
   localparam int ERR_RSV_WR = 1;
   localparam int ERR_WO_RD  = 2;
   localparam int ERR_RO_WR  = 3;
   localparam logic STATUS_IMPL = 1'b1;

   localparam int T_ONE_OF_N_ABSENT_FLAG   = 25;
   localparam int T_A3V    = 24;
   localparam int T_IDB_LO = 19;
   localparam int T_IDB_HI = 23;
   localparam int T_DIRECT_VIRTUAL_INJECTION_FLAG   = 18;
   localparam int T_LOCALITY_SPECIFIC_SUPPORT_FLAG   = 17;
   localparam int T_ITL_LO = 0;
   localparam int T_ITL_HI = 4;
   localparam logic       ONE_OF_N_ABSENT_FLAG_VAL   = 1'b1;
   localparam logic       A3V_VAL    = 1'b0;
   localparam logic [4:0] IDENTIFIER_WIDTH_FIELD_VAL = 5'h09;
   localparam logic       DIRECT_VIRTUAL_INJECTION_FLAG_VAL   = 1'b0;
   localparam logic       LOCALITY_SPECIFIC_SUPPORT_FLAG_VAL   = 1'b0;
   localparam logic [4:0] ITL_VAL    = 5'h03;
   localparam logic [NUM_PE-1:0] PE_IMPL = 8'hff;

   function automatic logic word_hit(input logic [11:0] a, input logic [11:0] off);
      return a[11:2] == off[11:2];
   endfunction

   function automatic logic [NUM_PE-1:0] pe_onehot(input logic [PE_W-1:0] p);
      return {{(NUM_PE-1){1'b0}}, 1'b1} << p;
   endfunction

   function automatic logic [31:0] be_mask(input logic [LANES-1:0] be);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < LANES; i++) begin
         m[i*BYTE_W +: BYTE_W] = {BYTE_W{be[i]}};
      end
      return m;
   endfunction

   function automatic logic pend_allow(input logic grp1, input logic sec_acc,
                                       input logic ds, input logic are_s,
                                       input logic are_ns);
      logic aff;
      aff = ds ? are_s : (grp1 ? are_ns : are_s);
      return !aff && (sec_acc || grp1);
   endfunction

   function automatic logic [31:0] type_word();
      logic [31:0] w;
      w = '0;
      w[T_ONE_OF_N_ABSENT_FLAG] = ONE_OF_N_ABSENT_FLAG_VAL;
      w[T_A3V] = A3V_VAL;
      w[T_IDB_HI:T_IDB_LO] = IDENTIFIER_WIDTH_FIELD_VAL;
      w[T_DIRECT_VIRTUAL_INJECTION_FLAG] = DIRECT_VIRTUAL_INJECTION_FLAG_VAL;
      w[T_LOCALITY_SPECIFIC_SUPPORT_FLAG] = LOCALITY_SPECIFIC_SUPPORT_FLAG_VAL;
      w[T_ITL_HI:T_ITL_LO] = ITL_VAL;
      return w;
   endfunction
endpackage

// ==== design/sgi_send_decode.sv ====
`timescale 1ns/1ps
module sgi_send_decode
   import sgi_dist_pkg::*;
(
   input  wire logic [31:0]        wdata,
   input  wire logic [PE_W-1:0]    requester,
   input  wire logic               sec_acc,
   input  wire logic [1:0]         nsacr_fld,
   input  wire logic [NUM_PE-1:0]  grp1_of_id,
   output logic      [NUM_PE-1:0]  targets
);
   logic [NUM_PE-1:0] base;
   logic [NUM_PE-1:0] grp_ok;

   always_comb begin
      unique case (filter_e'(wdata[FILT_HI:FILT_LO]))
         FILT_LIST:   base = wdata[LIST_HI:LIST_LO];
         FILT_OTHERS: base = ~pe_onehot(requester);
         FILT_SELF:   base = pe_onehot(requester);
         FILT_RSVD:   base = '0;
      endcase
      for (int t = 0; t < NUM_PE; t++) begin
         if (sec_acc) begin
            grp_ok[t] = grp1_of_id[t] == wdata[GRP_BIT];
         end else begin
            // Non-secure writers cannot pick the group, so configured group 1 targets pass, and group 0 ones only when nsacr_fld is nonzero.
            grp_ok[t] = grp1_of_id[t] || (nsacr_fld != 2'h0);
         end
      end
      targets = base & grp_ok & PE_IMPL;
   end
endmodule

// ==== design/access_error_status.sv ====
`timescale 1ns/1ps
module access_error_status
   import sgi_dist_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             arst_n,
   input  wire logic             ce,
   input  wire logic [ERR_W-1:0] err_event,
   input  wire logic             clr_valid,
   input  wire logic [ERR_W-1:0] clr_mask,
   input  wire logic             bank_ns,
   output logic      [ERR_W-1:0] flags_s,
   output logic      [ERR_W-1:0] flags_ns
);
   typedef struct packed {
      logic [ERR_W-1:0] s;
      logic [ERR_W-1:0] ns;
   } state_s;

   state_s st_q;
   state_s st_d;

   always_comb begin
      st_d = st_q;
      if (bank_ns) begin
         if (clr_valid) st_d.ns = st_d.ns & ~clr_mask;
         st_d.ns = st_d.ns | err_event;
      end else begin
         if (clr_valid) st_d.s = st_d.s & ~clr_mask;
         st_d.s = st_d.s | err_event;
      end
      if (!STATUS_IMPL) st_d = '0;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign flags_s  = st_q.s;
   assign flags_ns = st_q.ns;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   property p_err_set_wins;
      ce && !bank_ns && (err_event != '0) |=> (flags_s & $past(err_event)) == $past(err_event);
   endproperty
   a_err_set_wins: assert property (p_err_set_wins) else $error("error event lost");

   property p_err_w1c;
      ce && !bank_ns && clr_valid && (err_event == '0) |=> (flags_s & $past(clr_mask)) == '0;
   endproperty
   a_err_w1c: assert property (p_err_w1c) else $error("write one did not clear");

   property p_err_bank;
      ce && bank_ns |=> $stable(flags_s);
   endproperty
   a_err_bank: assert property (p_err_bank) else $error("secure copy touched");

   c_err_seen: cover property (ce && (err_event != '0));
endmodule

// ==== design/soft_interrupt_gen_and_status.sv ====
`timescale 1ns/1ps
module soft_interrupt_gen_and_status
   import sgi_dist_pkg::*;
(
   input  wire logic                              sys_clk,
   input  wire logic                              arst_n,
   input  wire logic                              ce,
   input  wire logic                              bus_req,
   input  wire logic                              bus_we,
   input  wire logic [11:0]                       bus_addr,
   input  wire logic [LANES-1:0]                  bus_be,
   input  wire logic [31:0]                       bus_wdata,
   input  wire logic                              bus_secure,
   input  wire logic [PE_W-1:0]                   bus_cpu,
   output logic      [31:0]                       bus_rdata,
   output logic                                   bus_ack,
   input  wire logic                              security_disabled,
   input  wire logic                              affinity_secure,
   input  wire logic                              affinity_nonsecure,
   input  wire logic [31:0]                       nonsecure_access_setting,
   input  wire logic [NUM_PE-1:0][NUM_SGI-1:0]    group1_cfg,
   input  wire logic                              pend_clr_valid,
   input  wire logic [PE_W-1:0]                   pend_clr_cpu,
   input  wire logic [ID_W-1:0]                   pend_clr_id,
   input  wire logic [PE_W-1:0]                   pend_clr_src,
   output logic                                   sgi_fwd_valid,
   output logic      [NUM_PE-1:0]                 sgi_fwd_targets,
   output logic      [ID_W-1:0]                   sgi_fwd_id,
   output logic      [PE_W-1:0]                   sgi_fwd_src,
   output logic      [31:0]                       send_held,
   output logic      [NUM_PE*NUM_SGI*NUM_PE-1:0]  pend_state
);
   typedef struct packed {
      logic [NUM_PE-1:0][NUM_SGI-1:0][NUM_PE-1:0] pend;
      logic [31:0]                                rdata;
      logic                                       ack;
      logic                                       fwd_valid;
      logic [NUM_PE-1:0]                          fwd_targets;
      logic [PE_W-1:0]                            fwd_src;
      logic [31:0]                                send;
   } state_s;

   state_s            st_q;
   state_s            st_d;
   logic              acc;
   logic              sec_acc;
   logic              aff_req;
   logic              hit_type;
   logic              hit_status;
   logic              hit_send;
   logic              hit_pend;
   logic              hit_any;
   logic              wr_send;
   logic              wr_pend;
   logic              rd_type;
   logic [1:0]        fld_filter;
   logic [NUM_PE-1:0] fld_list;
   logic [ID_W-1:0]   fld_id;
   logic [1:0]        nsacr_fld;
   logic [NUM_PE-1:0] grp_of_id;
   logic [NUM_PE-1:0] dec_targets;
   logic [LANES-1:0]  lane_allow;
   logic [31:0]       rd_pend;
   logic [31:0]       rd_status;
   logic [31:0]       rd_word;
   logic [ERR_W-1:0]  err_event;
   logic              err_clr;
   logic [ERR_W-1:0]  flags_s;
   logic [ERR_W-1:0]  flags_ns;

   assign acc        = bus_req && ce;
   assign sec_acc    = bus_secure || security_disabled;
   assign aff_req    = sec_acc ? affinity_secure : affinity_nonsecure;
   assign hit_type   = word_hit(bus_addr, OFF_TYPE);
   assign hit_status = word_hit(bus_addr, OFF_STATUS);
   assign hit_send   = word_hit(bus_addr, OFF_SEND);
   assign hit_pend   = (bus_addr & PEND_MASK) == OFF_PEND;
   assign hit_any    = hit_type || hit_status || hit_send || hit_pend;
   // Only whole-word writes generate, since a partial word would leave fields undefined.
   assign wr_send    = acc && bus_we && hit_send && (bus_be == BE_ALL);
   assign wr_pend    = acc && bus_we && hit_pend;
   assign rd_type    = acc && !bus_we && hit_type;
   assign fld_filter = bus_wdata[FILT_HI:FILT_LO];
   assign fld_list   = bus_wdata[LIST_HI:LIST_LO];
   assign fld_id     = bus_wdata[ID_HI:ID_LO];
   assign nsacr_fld  = nonsecure_access_setting[{fld_id, 1'b0} +: 2];

   always_comb begin
      for (int t = 0; t < NUM_PE; t++) begin
         grp_of_id[t] = group1_cfg[t][fld_id];
      end
   end

   sgi_send_decode u_decode (
      .wdata      (bus_wdata),
      .requester  (bus_cpu),
      .sec_acc    (sec_acc),
      .nsacr_fld  (nsacr_fld),
      .grp1_of_id (grp_of_id),
      .targets    (dec_targets)
   );

   // The accessing element sees its own copy; bit c of lane x is source c of number 4n+x.
   always_comb begin
      rd_pend = '0;
      for (int x = 0; x < LANES; x++) begin
         lane_allow[x] = pend_allow(group1_cfg[bus_cpu][{bus_addr[3:2], 2'(x)}], sec_acc,
                                    security_disabled, affinity_secure,
                                    affinity_nonsecure);
         if (lane_allow[x]) begin
            rd_pend[x*BYTE_W +: BYTE_W] = st_q.pend[bus_cpu][{bus_addr[3:2], 2'(x)}]
                                          & PE_IMPL;
         end
      end
   end

   access_error_status u_status (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .ce        (ce),
      .err_event (err_event),
      .clr_valid (err_clr),
      .clr_mask  (bus_wdata[ERR_W-1:0]),
      .bank_ns   (!sec_acc),
      .flags_s   (flags_s),
      .flags_ns  (flags_ns)
   );

   always_comb begin
      err_event             = '0;
      err_event[ERR_RO_WR]  = acc && bus_we && hit_type;
      err_event[ERR_WO_RD]  = acc && !bus_we && hit_send;
      err_event[ERR_RSV_WR] = acc && bus_we && !hit_any;
      err_event[ERR_RSV_RD] = acc && !bus_we && !hit_any;
      err_clr               = acc && bus_we && hit_status && bus_be[0];
      rd_status             = '0;
      if (STATUS_IMPL) begin
         rd_status[ERR_W-1:0] = sec_acc ? flags_s : flags_ns;
      end
   end

   always_comb begin
      if (hit_type) begin
         rd_word = type_word();
      end else if (hit_status) begin
         rd_word = rd_status;
      end else if (hit_pend) begin
         rd_word = rd_pend;
      end else begin
         rd_word = '0;
      end
   end

   always_comb begin
      st_d           = st_q;
      st_d.ack       = 1'b0;
      st_d.fwd_valid = 1'b0;
      st_d.rdata     = '0;
      // The clear is applied first so that a set in the same cycle wins.
      if (pend_clr_valid) begin
         st_d.pend[pend_clr_cpu][pend_clr_id][pend_clr_src] = 1'b0;
      end
      if (acc) begin
         st_d.ack = 1'b1;
         if (!bus_we) begin
            st_d.rdata = rd_word & be_mask(bus_be);
         end
         if (wr_send) begin
            st_d.send = bus_wdata & SEND_WMASK;
            if (!sec_acc) st_d.send[GRP_BIT] = 1'b0;
            if (!aff_req) begin
               st_d.fwd_targets = dec_targets;
               st_d.fwd_src     = bus_cpu;
               st_d.fwd_valid   = dec_targets != '0;
               for (int t = 0; t < NUM_PE; t++) begin
                  if (dec_targets[t]) st_d.pend[t][fld_id][bus_cpu] = 1'b1;
               end
            end
         end
         if (wr_pend) begin
            for (int x = 0; x < LANES; x++) begin
               for (int c = 0; c < NUM_PE; c++) begin
                  if (bus_be[x] && lane_allow[x] && PE_IMPL[c]
                      && bus_wdata[x*BYTE_W + c]) begin
                     st_d.pend[bus_cpu][{bus_addr[3:2], 2'(x)}][c] = 1'b1;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q             <= '0;
         st_q.send        <= SEND_RST;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign bus_rdata       = st_q.rdata;
   assign bus_ack         = st_q.ack;
   assign sgi_fwd_valid   = st_q.fwd_valid;
   assign sgi_fwd_targets = st_q.fwd_targets;
   assign sgi_fwd_id      = st_q.send[ID_HI:ID_LO];
   assign sgi_fwd_src     = st_q.fwd_src;
   assign send_held       = st_q.send;
   assign pend_state      = st_q.pend;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   property p_ack_next;
      acc |=> bus_ack;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not answered");

   property p_fwd_self;
      wr_send && !aff_req && (fld_filter == FILT_SELF) && (dec_targets != '0)
         |=> sgi_fwd_valid && (sgi_fwd_targets == pe_onehot($past(bus_cpu)));
   endproperty
   a_fwd_self: assert property (p_fwd_self) else $error("self filter wrong");

   property p_fwd_list;
      wr_send && !aff_req && (fld_filter == FILT_LIST)
         |=> (sgi_fwd_targets & ~$past(fld_list)) == '0;
   endproperty
   a_fwd_list: assert property (p_fwd_list) else $error("unlisted target");

   property p_fwd_empty;
      wr_send && (fld_filter == FILT_LIST) && (fld_list == '0) |=> !sgi_fwd_valid;
   endproperty
   a_fwd_empty: assert property (p_fwd_empty) else $error("empty list forwarded");

   property p_fwd_rsvd;
      wr_send && (fld_filter == FILT_RSVD) |=> !sgi_fwd_valid;
   endproperty
   a_fwd_rsvd: assert property (p_fwd_rsvd) else $error("reserved filter fired");

   property p_fwd_id;
      wr_send |=> sgi_fwd_id == $past(fld_id);
   endproperty
   a_fwd_id: assert property (p_fwd_id) else $error("wrong interrupt number");

   property p_ns_group;
      wr_send && !sec_acc && (nsacr_fld == 2'h0)
         |=> (sgi_fwd_targets & ~$past(grp_of_id)) == '0 || !sgi_fwd_valid;
   endproperty
   a_ns_group: assert property (p_ns_group) else $error("non-secure group 0 sent");

   property p_aff_block;
      wr_send && aff_req |=> !sgi_fwd_valid;
   endproperty
   a_aff_block: assert property (p_aff_block) else $error("sent under affinity");

   property p_zero_write;
      wr_pend && (bus_wdata == '0) && !pend_clr_valid |=> $stable(pend_state);
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("zero write changed state");

   property p_type_one_of_n_absent_flag;
      rd_type && bus_be[3] |=> bus_rdata[T_ONE_OF_N_ABSENT_FLAG] == ONE_OF_N_ABSENT_FLAG_VAL;
   endproperty
   a_type_one_of_n_absent_flag: assert property (p_type_one_of_n_absent_flag) else $error("one-of-N flag wrong");

   property p_type_range;
      rd_type && bus_be[0] |=> bus_rdata[T_ITL_HI:T_ITL_LO] == ITL_VAL;
   endproperty
   a_type_range: assert property (p_type_range) else $error("range field wrong");

   property p_ack_pulse;
      ce && !acc |=> !bus_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge stretched");

   property p_fwd_others;
      wr_send && !aff_req && (fld_filter == FILT_OTHERS)
         |=> (sgi_fwd_targets & pe_onehot($past(bus_cpu))) == '0;
   endproperty
   a_fwd_others: assert property (p_fwd_others) else $error("requester kept");

   property p_grp_secure;
      wr_send && sec_acc && !aff_req
         |=> (sgi_fwd_targets & ($past(grp_of_id) ^ {NUM_PE{$past(bus_wdata[GRP_BIT])}})) == '0;
   endproperty
   a_grp_secure: assert property (p_grp_secure) else $error("wrong group sent");

   property p_ns_grp_bit;
      wr_send && !sec_acc |=> !send_held[GRP_BIT];
   endproperty
   a_ns_grp_bit: assert property (p_ns_grp_bit) else $error("group bit kept");

   property p_fwd_src;
      wr_send && !aff_req |=> sgi_fwd_src == $past(bus_cpu);
   endproperty
   a_fwd_src: assert property (p_fwd_src) else $error("wrong source");

   property p_send_pends;
      wr_send && !aff_req && dec_targets[0]
         |=> st_q.pend[0][$past(fld_id)][$past(bus_cpu)];
   endproperty
   a_send_pends: assert property (p_send_pends) else $error("send did not pend");

   property p_no_lane;
      wr_pend && !bus_be[2] && !pend_clr_valid
         |=> st_q.pend[$past(bus_cpu)][{$past(bus_addr[3:2]), 2'b10}]
             == $past(st_q.pend[bus_cpu][{bus_addr[3:2], 2'b10}]);
   endproperty
   a_no_lane: assert property (p_no_lane) else $error("disabled lane written");

   property p_ns_grp0_rd;
      acc && !bus_we && hit_pend && !sec_acc && bus_be[1]
         && !group1_cfg[bus_cpu][{bus_addr[3:2], 2'b01}] |=> bus_rdata[2*BYTE_W-1:BYTE_W] == '0;
   endproperty
   a_ns_grp0_rd: assert property (p_ns_grp0_rd) else $error("group 0 bit visible");

   property p_aff_rd;
      acc && !bus_we && hit_pend && affinity_secure && bus_be[1]
         && !group1_cfg[bus_cpu][{bus_addr[3:2], 2'b01}] |=> bus_rdata[2*BYTE_W-1:BYTE_W] == '0;
   endproperty
   a_aff_rd: assert property (p_aff_rd) else $error("pending read under affinity");

   property p_rsvd_flag;
      acc && !bus_we && !hit_any && sec_acc |=> flags_s[ERR_RSV_RD];
   endproperty
   a_rsvd_flag: assert property (p_rsvd_flag) else $error("reserved read not flagged");

   property p_status_rd;
      acc && !bus_we && hit_status && bus_be[0]
         |=> bus_rdata[ERR_W-1:0] == ($past(sec_acc) ? $past(flags_s) : $past(flags_ns));
   endproperty
   a_status_rd: assert property (p_status_rd) else $error("wrong status copy");

   property p_type_identifier_width_field;
      rd_type && bus_be[2] |=> bus_rdata[T_IDB_HI:T_IDB_LO] == IDENTIFIER_WIDTH_FIELD_VAL;
   endproperty
   a_type_identifier_width_field: assert property (p_type_identifier_width_field) else $error("id width wrong");

   property p_type_flags;
      rd_type && bus_be[3] && bus_be[2]
         |=> bus_rdata[T_A3V] == A3V_VAL && bus_rdata[T_DIRECT_VIRTUAL_INJECTION_FLAG] == DIRECT_VIRTUAL_INJECTION_FLAG_VAL
             && bus_rdata[T_LOCALITY_SPECIFIC_SUPPORT_FLAG] == LOCALITY_SPECIFIC_SUPPORT_FLAG_VAL;
   endproperty
   a_type_flags: assert property (p_type_flags) else $error("feature flags wrong");

   c_fwd_list: cover property (wr_send && (fld_filter == FILT_LIST) ##1 sgi_fwd_valid);
   c_byte_pend: cover property (wr_pend && (bus_be != BE_ALL) && (bus_wdata != '0));
   c_clr_race: cover property (pend_clr_valid && wr_send);
endmodule

// ==== sim/cpu_iface_model.sv ====
`timescale 1ns/1ps
module cpu_iface_model
   import sgi_dist_pkg::*;
(
   input  wire logic            sys_clk,
   input  wire logic            arst_n,
   input  wire logic            act_req,
   input  wire logic [PE_W-1:0] act_cpu,
   input  wire logic [ID_W-1:0] act_id,
   input  wire logic [PE_W-1:0] act_src,
   output logic                 pend_clr_valid,
   output logic      [PE_W-1:0] pend_clr_cpu,
   output logic      [ID_W-1:0] pend_clr_id,
   output logic      [PE_W-1:0] pend_clr_src
);
   // An interface takes one interrupt per request, which removes its pending state.
   // Between pulses the qualifiers toggle, so stale values cannot pass for a real request.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_clr_valid <= 1'b0;
         pend_clr_cpu   <= '0;
         pend_clr_id    <= '0;
         pend_clr_src   <= '0;
      end else if (act_req) begin
         pend_clr_valid <= 1'b1;
         pend_clr_cpu   <= act_cpu;
         pend_clr_id    <= act_id;
         pend_clr_src   <= act_src;
      end else begin
         pend_clr_valid <= 1'b0;
         pend_clr_cpu   <= ~pend_clr_cpu;
         pend_clr_id    <= ~pend_clr_id;
         pend_clr_src   <= ~pend_clr_src;
      end
   end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import sgi_dist_pkg::*;
   logic                          sys_clk, arst_n, bus_req, bus_we, bus_secure, bus_ack;
   logic                          aff_s, aff_ns, act_req, pcv, fwd_v, ds;
   logic [11:0]                   bus_addr;
   logic [3:0]                    bus_be, act_id, pci, fwd_id;
   logic [2:0]                    bus_cpu, act_cpu, act_src, pcc, pcs, fwd_src;
   logic [31:0]                   bus_wdata, bus_rdata, nsacr, held, rd;
   logic [7:0]                    fwd_t;
   logic [NUM_PE-1:0][NUM_SGI-1:0] g1;
   logic [1023:0]                 pend;
   logic [7:0]                    exp_t [3] = '{8'h13, 8'hfb, 8'h04};
   int                            err_count = 0;
   int                            n_compared = 0;

   soft_interrupt_gen_and_status i_soft_interrupt_gen_and_status (
      .sys_clk(sys_clk), .arst_n(arst_n), .ce(1'b1), .bus_req(bus_req), .bus_we(bus_we),
      .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_secure(bus_secure),
      .bus_cpu(bus_cpu), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .security_disabled(ds),
      .affinity_secure(aff_s), .affinity_nonsecure(aff_ns),
      .nonsecure_access_setting(nsacr), .group1_cfg(g1), .pend_clr_valid(pcv),
      .pend_clr_cpu(pcc), .pend_clr_id(pci), .pend_clr_src(pcs), .sgi_fwd_valid(fwd_v),
      .sgi_fwd_targets(fwd_t), .sgi_fwd_id(fwd_id), .sgi_fwd_src(fwd_src),
      .send_held(held), .pend_state(pend));

   cpu_iface_model i_cpu_iface_model (
      .sys_clk(sys_clk), .arst_n(arst_n), .act_req(act_req), .act_cpu(act_cpu),
      .act_id(act_id), .act_src(act_src), .pend_clr_valid(pcv), .pend_clr_cpu(pcc),
      .pend_clr_id(pci), .pend_clr_src(pcs));

   task automatic complete_run();
      if (err_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask

   // Requests last exactly one cycle: the block takes a new one at every edge with req high.
   task automatic acc(input logic we, input logic [11:0] a, input logic [3:0] be,
                      input logic [31:0] d, input logic sec, input logic [2:0] c);
      int n;
      // An idle edge first, so back-to-back calls never drop and raise the request at once.
      @(posedge sys_clk);
      #1;
      bus_req = 1'b1;
      bus_we = we;
      bus_addr = a;
      bus_be = be;
      bus_wdata = d;
      bus_secure = sec;
      bus_cpu = c;
      @(posedge sys_clk);
      #1;
      bus_req = 1'b0;
      bus_wdata = ~d;
      n = 0;
      while (bus_ack !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      rd = bus_rdata;
      if (n == 20) begin
         err_count++;
         complete_run();
      end
   endtask

   task automatic snd(input logic [1:0] f, input logic [7:0] l, input logic g,
                      input logic [3:0] id, input logic sec, input logic [2:0] c);
      acc(1'b1, 12'hf00, 4'hf, {6'h00, f, l, g, 11'h000, id}, sec, c);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      arst_n = 1'b0;
      bus_req = 1'b0;
      bus_we = 1'b0;
      bus_addr = 12'h000;
      bus_be = 4'h0;
      bus_wdata = 32'h0;
      bus_secure = 1'b1;
      bus_cpu = 3'h0;
      aff_s = 1'b0;
      aff_ns = 1'b0;
      nsacr = 32'h0;
      g1 = '0;
      g1[1][7] = 1'b1;
      act_req = 1'b0;
      act_cpu = 3'h3;
      act_id = 4'h9;
      act_src = 3'h0;
      ds = 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      chk("send_held", 32'h007f0000, held);
      acc(1'b0, 12'h004, 4'hf, 32'h0, 1'b1, 3'h0);
      chk("type", 32'h02480003, rd);
      for (int f = 0; f < 4; f++) begin
         snd(f[1:0], 8'h13, 1'b0, 4'h5, 1'b1, 3'h2);
         chk("fwd_valid", {31'h0, f != 3}, {31'h0, fwd_v});
         if (f != 3) begin
            chk("targets", {24'h0, exp_t[f]}, {24'h0, fwd_t});
            chk("fwd_id", 32'h5, {28'h0, fwd_id});
            chk("fwd_src", 32'h2, {29'h0, fwd_src});
         end
      end
      chk("pend_state", 32'h1, {31'h0, pend[(7*NUM_SGI+5)*NUM_PE+2]});
      acc(1'b0, 12'hf24, 4'hf, 32'h0, 1'b1, 3'h0);
      chk("pend_f24", 32'h00000400, rd);
      snd(2'b00, 8'h00, 1'b0, 4'h5, 1'b1, 3'h2);
      chk("empty_list", 32'h0, {31'h0, fwd_v});
      snd(2'b00, 8'h03, 1'b1, 4'h7, 1'b1, 3'h0);
      chk("grp1", 32'h02, {24'h0, fwd_t});
      snd(2'b00, 8'h03, 1'b0, 4'h7, 1'b1, 3'h0);
      chk("grp0", 32'h01, {24'h0, fwd_t});
      snd(2'b00, 8'h03, 1'b1, 4'h7, 1'b0, 3'h0);
      chk("ns_grp", 32'h02, {24'h0, fwd_t});
      chk("ns_held", 32'h00030007, held);
      nsacr[15:14] = 2'b01;
      snd(2'b00, 8'h03, 1'b0, 4'h7, 1'b0, 3'h0);
      chk("ns_allowed", 32'h03, {24'h0, fwd_t});
      acc(1'b1, 12'hf28, 4'h2, 32'h00818100, 1'b1, 3'h3);
      acc(1'b1, 12'hf28, 4'hf, 32'h0, 1'b1, 3'h3);
      acc(1'b0, 12'hf28, 4'hf, 32'h0, 1'b1, 3'h3);
      chk("pend_word", 32'h00008100, rd);
      acc(1'b0, 12'hf28, 4'h2, 32'h0, 1'b1, 3'h3);
      chk("pend_byte", 32'h00008100, rd);
      acc(1'b0, 12'hf28, 4'hf, 32'h0, 1'b0, 3'h3);
      chk("pend_ns", 32'h0, rd);
      act_req = 1'b1;
      @(posedge sys_clk);
      #1;
      act_req = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      acc(1'b0, 12'hf28, 4'hf, 32'h0, 1'b1, 3'h3);
      chk("pend_taken", 32'h00008000, rd);
      acc(1'b0, 12'hf28, 4'hf, 32'h0, 1'b1, 3'h0);
      chk("pend_other_pe", 32'h0, rd);
      acc(1'b0, 12'hf00, 4'hf, 32'h0, 1'b1, 3'h0);
      acc(1'b1, 12'h004, 4'hf, 32'h0, 1'b1, 3'h0);
      acc(1'b1, 12'h200, 4'hf, 32'h0, 1'b1, 3'h0);
      acc(1'b0, 12'h200, 4'hf, 32'h0, 1'b1, 3'h0);
      acc(1'b0, 12'h010, 4'hf, 32'h0, 1'b1, 3'h0);
      chk("status_s", 32'hf, rd);
      acc(1'b0, 12'h010, 4'hf, 32'h0, 1'b0, 3'h0);
      chk("status_ns", 32'h0, rd);
      acc(1'b1, 12'h010, 4'hf, 32'h5, 1'b1, 3'h0);
      acc(1'b0, 12'h200, 4'hf, 32'h0, 1'b0, 3'h0);
      acc(1'b0, 12'h010, 4'hf, 32'h0, 1'b0, 3'h0);
      chk("status_ns2", 32'h1, rd);
      acc(1'b0, 12'h010, 4'hf, 32'h0, 1'b1, 3'h0);
      chk("status_clr", 32'ha, rd);
      aff_s = 1'b1;
      snd(2'b00, 8'h01, 1'b0, 4'h2, 1'b1, 3'h0);
      chk("aff_fwd", 32'h0, {31'h0, fwd_v});
      acc(1'b0, 12'hf24, 4'hf, 32'h0, 1'b1, 3'h0);
      chk("aff_pend", 32'h0, rd);
      ds = 1'b1;
      acc(1'b0, 12'h010, 4'hf, 32'h0, 1'b0, 3'h0);
      chk("status_ds", 32'ha, rd);
      complete_run();
   end
endmodule
